// ==== sbi_irq_sources.sv ====
// Operation
// - Error flag sets on timing, parity, NACK, underrun or overrun.
// - Timing errors any role/field; parity off-data individual, anywhere broadcast.
// - NACK error off-data individual; underrun on tx data; overrun broadcast rx data.
// - Master: start after address field; always on lost arbitration.
// - Slave: start after address field only when this unit is addressed.
// - Slave: status interrupt in control field regardless of transmit enable.
// - Status interrupt also when NACK returned in control field.
// - End-of-communication flag when success counter reaches zero in data.
// - End-of-frame flag when frame counter reaches zero in data.
// - Transmit write request each time buffered byte moves to shift register, except for the last byte of the transfer or frame.
// - Receive read request only after an error-free received data byte.
// - Requests split into vector CPU interrupts and DMA start requests.
// - DMA start request is OR of transmit write and receive read.
// - Vector interrupt is OR of the five status flags.
// - Success counter drops on acked data bytes; frame counter on every data byte.
//
// Our own choices: the register addresses and register access over APB.
module sbi_irq_sources (
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     arst_n_i,
	// APB slave
	input  wire logic                     psel_i,
	input  wire logic                     penable_i,
	input  wire logic                     pwrite_i,
	input  wire logic [7:0]               paddr_i,
	input  wire logic [31:0]              pwdata_i,
	output logic      [31:0]              prdata_o,
	output logic                          pready_o,
	output logic                          pslverr_o,
	// Protocol engine
	input  wire sbi_pkg::sbi_ctx_type     ctx_i,
	input  wire sbi_pkg::sbi_evt_type     evt_i,
	// Data register service by DMA or CPU
	input  wire logic                     tx_data_written_i,
	input  wire logic                     rx_data_read_i,
	// Requests
	output logic                          vector_irq_request_o,
	output logic                          dma_start_request_o,
	output logic                          irq_o
);

	// ---- APB decode ----
	sbi_pkg::sbi_apb_req_type req;
	logic                     pready_ff;
	logic                     nxt_pready;
	logic [31:0]              prdata_ff;
	logic [31:0]              nxt_prdata;
	logic                     pslverr_ff;
	logic                     nxt_pslverr;

	assign req.psel    = psel_i;
	assign req.penable = penable_i;
	assign req.pwrite  = pwrite_i;
	assign req.paddr   = paddr_i;
	assign req.pwdata  = pwdata_i;

	wire access  = req.psel && req.penable;
	wire commit  = access && pready_ff;
	wire wr_en   = commit && req.pwrite;
	wire sel_st  = (req.paddr == sbi_pkg::ADDR_STATUS);
	wire sel_msk = (req.paddr == sbi_pkg::ADDR_MASK);
	wire sel_len = (req.paddr == sbi_pkg::ADDR_LENGTH);
	wire sel_sc  = (req.paddr == sbi_pkg::ADDR_SCNT);
	wire sel_fc  = (req.paddr == sbi_pkg::ADDR_FCNT);
	// Unmapped offsets answer with an error, writes dropped
	wire mapped  = sel_st || sel_msk || sel_len || sel_sc || sel_fc;

	// One wait state: pready rises in the second access cycle
	assign nxt_pready  = access && !pready_ff;
	assign nxt_pslverr = access && !pready_ff && !mapped;

	// ---- Registers ----
	sbi_pkg::sbi_flags_type status_ff;
	sbi_pkg::sbi_flags_type nxt_status;
	logic [6:0]             mask_ff;
	logic [6:0]             nxt_mask;
	logic [7:0]             length_ff;
	logic [7:0]             nxt_length;
	logic                   vec_ff;
	logic                   dma_ff;
	logic                   irq_ff;

	// ---- Counters ----
	logic [8:0] scnt;
	logic [8:0] fcnt;
	logic       scnt_zero;
	logic       fcnt_zero;

	// ---- Event qualification ----
	sbi_pkg::sbi_ctx_type ctx;
	sbi_pkg::sbi_evt_type evt;

	assign ctx = ctx_i;
	assign evt = evt_i;

	wire in_data = (ctx.field == sbi_pkg::FLD_DATA);
	wire in_ctrl = (ctx.field == sbi_pkg::FLD_CONTROL);
	wire is_rx   = !ctx.is_xmit;

	wire err_timing = evt.timing_err;
	wire err_parity = evt.parity_err && is_rx &&
		(ctx.is_broadcast || !in_data);
	wire err_nack   = evt.nack && !ctx.is_broadcast && !in_data;
	wire err_under  = evt.underrun && ctx.is_xmit && in_data;
	wire err_over   = evt.overrun && is_rx && ctx.is_broadcast &&
		in_data;

	wire set_err = err_timing || err_parity || err_nack ||
		err_under || err_over;

	wire start_master = ctx.is_master && evt.addr_done;
	wire start_lost   = evt.arb_lost;
	wire start_slave  = !ctx.is_master && evt.addr_done &&
		ctx.slave_match;
	wire set_start    = start_master || start_lost || start_slave;

	// Slave status interrupt ignores the transmit enable
	wire stat_ctrl = !ctx.is_master && evt.ctrl_done;
	wire stat_nack = evt.nack && in_ctrl;
	wire set_stat  = stat_ctrl || stat_nack;

	// Counter stepping on data bytes
	wire data_byte = evt.byte_done && in_data;
	wire dec_scnt  = data_byte && evt.byte_ack;
	wire dec_fcnt  = data_byte;

	wire set_endc = scnt_zero;
	wire set_endf = fcnt_zero;

	// Last byte: only one left in the transfer or the frame
	wire last_byte = (scnt == 9'h001) || (fcnt == 9'h001);
	wire set_txw   = evt.tx_shift_load && ctx.is_xmit && in_data &&
		!last_byte;
	wire set_rxr   = data_byte && is_rx && evt.byte_ok;

	// Length 0 means 256 bytes
	wire [8:0] scnt_load = {(length_ff == 8'h00), length_ff};

	// Frame start reloads both counters; load beats a step
	sbi_byte_counter #(
		.WIDTH (9)
	) u_success_cnt (
		.clk_i      (clk_i),
		.arst_n_i   (arst_n_i),
		.load_i     (evt.frame_start),
		.load_val_i (scnt_load),
		.rst_val_i  (sbi_pkg::SCNT_RST),
		.dec_i      (dec_scnt),
		.count_o    (scnt),
		.hit_zero_o (scnt_zero)
	);

	sbi_byte_counter #(
		.WIDTH (9)
	) u_frame_cnt (
		.clk_i      (clk_i),
		.arst_n_i   (arst_n_i),
		.load_i     (evt.frame_start),
		.load_val_i (sbi_pkg::FRAME_MAX_BYTES),
		.rst_val_i  (sbi_pkg::FCNT_RST),
		.dec_i      (dec_fcnt),
		.count_o    (fcnt),
		.hit_zero_o (fcnt_zero)
	);

	// ---- Status set / clear ----
	sbi_pkg::sbi_flags_type set_vec;
	logic [6:0]             clr_vec;

	assign set_vec.comm_error_flag   = set_err;
	assign set_vec.start_flag        = set_start;
	assign set_vec.status_comm_flag  = set_stat;
	assign set_vec.end_of_comm_flag  = set_endc;
	assign set_vec.end_of_frame_flag = set_endf;
	assign set_vec.tx_write_request  = set_txw;
	assign set_vec.rx_read_request   = set_rxr;

	// Write one to clear; DR service clears the data requests
	wire [6:0] sw_clr = (wr_en && sel_st) ? pwdata_i[6:0] : 7'h00;
	assign clr_vec = sw_clr |
		(7'(tx_data_written_i) << sbi_pkg::BIT_TX_WRITE) |
		(7'(rx_data_read_i) << sbi_pkg::BIT_RX_READ);

	// Set wins over a clear in the same cycle
	generate
		for (genvar gi = 0; gi < sbi_pkg::FLAG_W; gi++)
		begin : g_flag
			assign nxt_status[gi] = set_vec[gi] ||
				(status_ff[gi] && !clr_vec[gi]);
		end
	endgenerate
	assign nxt_mask   = (wr_en && sel_msk) ? pwdata_i[6:0] : mask_ff;
	assign nxt_length = (wr_en && sel_len) ? pwdata_i[7:0] : length_ff;

	// ---- Request outputs ----
	wire nxt_vec = nxt_status.comm_error_flag ||
		nxt_status.start_flag || nxt_status.status_comm_flag ||
		nxt_status.end_of_comm_flag ||
		nxt_status.end_of_frame_flag;
	wire nxt_dma = nxt_status.tx_write_request ||
		nxt_status.rx_read_request;
	wire nxt_irq = |(nxt_status & nxt_mask);

	// ---- Read mux ----
	// Read words, unused high bits read as zero
	wire [31:0] rd_status = {25'h0, status_ff};
	wire [31:0] rd_mask   = {25'h0, mask_ff};
	wire [31:0] rd_length = {24'h0, length_ff};
	wire [31:0] rd_scnt   = {24'h0, scnt[7:0]};
	wire [31:0] rd_fcnt   = {24'h0, fcnt[7:0]};

	// Word launched in the wait state, stands with pready
	assign nxt_prdata = !nxt_pready ? 32'h0000_0000 :
		sel_st  ? rd_status :
		sel_msk ? rd_mask :
		sel_len ? rd_length :
		sel_sc  ? rd_scnt :
		sel_fc  ? rd_fcnt : 32'h0000_0000;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end
		else
		begin
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff  <= nxt_prdata;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			status_ff <= sbi_pkg::STATUS_RST;
		end
		else
		begin
			status_ff <= nxt_status;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			mask_ff <= sbi_pkg::MASK_RST;
		end
		else
		begin
			mask_ff <= nxt_mask;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			length_ff <= sbi_pkg::LENGTH_RST;
		end
		else
		begin
			length_ff <= nxt_length;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			vec_ff <= 1'b0;
			dma_ff <= 1'b0;
		end
		else
		begin
			vec_ff <= nxt_vec;
			dma_ff <= nxt_dma;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			irq_ff <= 1'b0;
		end
		else
		begin
			irq_ff <= nxt_irq;
		end
	end

	// Every output comes straight from a flop
	assign prdata_o             = prdata_ff;
	assign pready_o             = pready_ff;
	assign pslverr_o            = pslverr_ff;
	assign vector_irq_request_o = vec_ff;
	assign dma_start_request_o  = dma_ff;
	assign irq_o                = irq_ff;

endmodule // sbi_irq_sources

// ==== sbi_pkg.sv ====
package sbi_pkg;

	// APB register byte offsets
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_MASK   = 8'h04;
	localparam logic [7:0] ADDR_LENGTH = 8'h08;
	localparam logic [7:0] ADDR_SCNT   = 8'h0c;
	localparam logic [7:0] ADDR_FCNT   = 8'h10;

	// Flag field positions in status and mask
	localparam int BIT_COMM_ERROR  = 0;
	localparam int BIT_START       = 1;
	localparam int BIT_STATUS_COMM = 2;
	localparam int BIT_END_OF_COMM = 3;
	localparam int BIT_END_OF_FRM  = 4;
	localparam int BIT_TX_WRITE    = 5;
	localparam int BIT_RX_READ     = 6;
	localparam int FLAG_W          = 7;

	// Values after reset
	localparam logic [6:0] STATUS_RST = 7'h00;
	localparam logic [6:0] MASK_RST   = 7'h00;
	localparam logic [7:0] LENGTH_RST = 8'h01;
	localparam logic [8:0] SCNT_RST   = 9'h001;
	localparam logic [8:0] FCNT_RST   = 9'h020;

	// Bytes per frame preset of the frame counter
	localparam logic [8:0] FRAME_MAX_BYTES = 9'h020;

	// Bus field the protocol engine is in
	typedef enum logic [2:0] {
		FLD_IDLE,
		FLD_HEADER,
		FLD_ADDRESS,
		FLD_CONTROL,
		FLD_LENGTH,
		FLD_DATA
	} sbi_field_type;

	// Frame context, levels from the protocol engine
	typedef struct packed {
		logic          is_master;
		logic          is_xmit;
		logic          is_broadcast;
		logic          slave_match;
		sbi_field_type field;
	} sbi_ctx_type;

	// One-cycle event pulses from the protocol engine
	typedef struct packed {
		logic timing_err;
		logic parity_err;
		logic nack;
		logic underrun;
		logic overrun;
		logic addr_done;
		logic arb_lost;
		logic ctrl_done;
		logic byte_done;
		logic byte_ack;
		logic byte_ok;
		logic tx_shift_load;
		logic frame_start;
	} sbi_evt_type;

	// Status / mask layout, bit 0 at the bottom
	typedef struct packed {
		logic rx_read_request;
		logic tx_write_request;
		logic end_of_frame_flag;
		logic end_of_comm_flag;
		logic status_comm_flag;
		logic start_flag;
		logic comm_error_flag;
	} sbi_flags_type;

	// APB request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} sbi_apb_req_type;

endpackage : sbi_pkg

// ==== sbi_byte_counter.sv ====
module sbi_byte_counter #(
	parameter int WIDTH = 9
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             arst_n_i,
	// Control
	input  wire logic             load_i,
	input  wire logic [WIDTH-1:0] load_val_i,
	input  wire logic [WIDTH-1:0] rst_val_i,
	input  wire logic             dec_i,
	// State
	output logic      [WIDTH-1:0] count_o,
	output logic                  hit_zero_o
);

	logic [WIDTH-1:0] count_ff;
	logic [WIDTH-1:0] nxt_count;
	wire              at_one;
	wire              at_zero;

	assign at_one     = (count_ff == WIDTH'(1));
	assign at_zero    = (count_ff == '0);
	assign hit_zero_o = dec_i && at_one && !load_i;
	assign count_o    = count_ff;

	// Load wins; no wrap below zero
	assign nxt_count = load_i ? load_val_i :
		(dec_i && !at_zero) ? count_ff - WIDTH'(1) : count_ff;

	// Reset clears the count; the first clock after reset loads the package constant wired in at the top, or load_val_i if load_i is high
	logic [WIDTH-1:0] seed_val;
	logic             rst_done_ff;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			count_ff    <= '0;
			rst_done_ff <= 1'b0;
		end
		else
		begin
			count_ff    <= rst_done_ff ? nxt_count : seed_val;
			rst_done_ff <= 1'b1;
		end
	end

	assign seed_val = load_i ? load_val_i : rst_val_i;

endmodule // sbi_byte_counter

// ==== sbi_irq_sources_chk.sv ====
module sbi_irq_sources_chk (
	// Clock and reset
	input wire logic                 clk_i,
	input wire logic                 arst_n_i,
	// APB
	input wire logic                 psel_i,
	input wire logic                 penable_i,
	input wire logic                 pwrite_i,
	input wire logic [7:0]           paddr_i,
	input wire logic [31:0]          pwdata_i,
	input wire logic [31:0]          prdata_o,
	input wire logic                 pready_o,
	input wire logic                 pslverr_o,
	// Engine and service
	input wire sbi_pkg::sbi_ctx_type ctx_i,
	input wire sbi_pkg::sbi_evt_type evt_i,
	input wire logic                 tx_data_written_i,
	input wire logic                 rx_data_read_i,
	// Requests
	input wire logic                 vector_irq_request_o,
	input wire logic                 dma_start_request_o,
	input wire logic                 irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// Completed write to the status register
	wire logic clr = psel_i && penable_i && pwrite_i && pready_o &&
		paddr_i == sbi_pkg::ADDR_STATUS;
	property p_err; evt_i.timing_err |=> vector_irq_request_o; endproperty
	a_err: assert property (p_err)
		else $error("error flag missed");
	property p_mstart;
		(evt_i.addr_done && ctx_i.is_master) || evt_i.arb_lost
		|=> vector_irq_request_o;
	endproperty
	a_mstart: assert property (p_mstart)
		else $error("master start missed");
	property p_sstart;
		evt_i.addr_done && !ctx_i.is_master && ctx_i.slave_match
		|=> vector_irq_request_o;
	endproperty
	a_sstart: assert property (p_sstart)
		else $error("slave start missed");
	property p_stat;
		evt_i.ctrl_done && !ctx_i.is_master |=> vector_irq_request_o;
	endproperty
	a_stat: assert property (p_stat)
		else $error("status flag missed");
	property p_nack;
		evt_i.nack && ctx_i.field == sbi_pkg::FLD_CONTROL
		|=> vector_irq_request_o;
	endproperty
	a_nack: assert property (p_nack)
		else $error("control nack missed");
	property p_rx;
		evt_i.byte_done && evt_i.byte_ok && !ctx_i.is_xmit &&
		ctx_i.field == sbi_pkg::FLD_DATA |=> dma_start_request_o;
	endproperty
	a_rx: assert property (p_rx)
		else $error("read request missed");
	property p_hold;
		vector_irq_request_o && !clr && !$past(clr)
		|=> vector_irq_request_o;
	endproperty
	a_hold: assert property (p_hold)
		else $error("flag dropped early");
	property p_quiet;
		!dma_start_request_o && !evt_i.tx_shift_load && !evt_i.byte_done
		|=> !dma_start_request_o;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("dma without cause");
	c_irq: cover property (irq_o);
	c_dma: cover property (dma_start_request_o);
	c_err: cover property (pslverr_o);
endmodule // sbi_irq_sources_chk

bind sbi_irq_sources sbi_irq_sources_chk u_chk (.clk_i(clk_i),
	.arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.ctx_i(ctx_i), .evt_i(evt_i), .tx_data_written_i(tx_data_written_i),
	.rx_data_read_i(rx_data_read_i), .irq_o(irq_o),
	.vector_irq_request_o(vector_irq_request_o),
	.dma_start_request_o(dma_start_request_o));

// ==== sbi_dma_model.sv ====
module sbi_dma_model #(
	parameter int DELAY = 2
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	// Request side
	input  wire logic en_i,
	input  wire logic xmit_i,
	input  wire logic dma_req_i,
	// Data register service
	output logic      tx_done_o,
	output logic      rx_done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_ff;
	logic       pulse_ff;
	wire logic  fire = en_i && dma_req_i && wait_ff == 4'(DELAY);
	wire logic [3:0] nxt_wait = (en_i && dma_req_i && !fire) ?
		wait_ff + 4'h1 : 4'h0;
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			wait_ff <= 4'h0;
			pulse_ff <= 1'b0;
		end
		else
		begin
			wait_ff <= nxt_wait;
			pulse_ff <= fire;
		end
	end
	// One service pulse clears the serviced request
	assign tx_done_o = pulse_ff && xmit_i;
	assign rx_done_o = pulse_ff && !xmit_i;
endmodule // sbi_dma_model

// ==== sbi_irq_sources_test.sv ====
module sbi_irq_sources_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic                 clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic                 vec, dma, irq, txd, rxd, en, er;
	logic [7:0]           paddr;
	logic [31:0]          pwdata, prdata, r;
	sbi_pkg::sbi_ctx_type ctx;
	sbi_pkg::sbi_evt_type evt;
	int                   bad_count = 0, n_tests = 0, cyc = 0;
	// Event, frame context, expected status
	logic [12:0] t_e[14] = '{13'h1000, 13'h0800, 13'h0800, 13'h0400, 13'h0400,
		13'h0200, 13'h0100, 13'h0100, 13'h0080, 13'h0080, 13'h0080, 13'h0040,
		13'h0020, 13'h0400};
	logic [6:0]  t_c[14] = '{7'h61, 7'h15, 7'h05, 7'h02, 7'h05, 7'h25, 7'h15,
		7'h05, 7'h62, 7'h02, 7'h0a, 7'h62, 7'h2b, 7'h0b};
	logic [6:0]  t_s[14] = '{7'h01, 7'h01, 7'h00, 7'h01, 7'h00, 7'h01, 7'h01,
		7'h00, 7'h02, 7'h00, 7'h02, 7'h02, 7'h04, 7'h05};

	sbi_irq_sources u_sbi_irq_sources (.clk_i(clk), .arst_n_i(arst_n),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .ctx_i(ctx), .evt_i(evt), .tx_data_written_i(txd),
		.rx_data_read_i(rxd), .vector_irq_request_o(vec),
		.dma_start_request_o(dma), .irq_o(irq));
	sbi_dma_model u_sbi_dma_model (.clk_i(clk), .arst_n_i(arst_n), .en_i(en),
		.xmit_i(ctx.is_xmit), .dma_req_i(dma), .tx_done_o(txd), .rx_done_o(rxd));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic summarize;
		$display("compares %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			bad_count++;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Hold the request until pready is seen at a rising edge
		do
			@(posedge clk);
		while (pready !== 1'b1);
		chk(32'(pready), 32'h1);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask

	task automatic ev(input logic [12:0] e, input logic [6:0] c);
		@(posedge clk);
		ctx <= sbi_pkg::sbi_ctx_type'(c);
		evt <= sbi_pkg::sbi_evt_type'(e);
		@(posedge clk);
		evt <= '0;
		@(negedge clk);
	endtask

	// Let the partner service the pending data request
	task automatic serve;
		@(posedge clk);
		en <= 1'b1;
		repeat (20)
		begin
			@(negedge clk);
			if (dma === 1'b0)
				break;
		end
		chk(32'(dma), 32'h0);
		@(posedge clk);
		en <= 1'b0;
	endtask

	task automatic t_regs;
		rd(sbi_pkg::ADDR_FCNT, 32'(sbi_pkg::FCNT_RST));
		rd(sbi_pkg::ADDR_LENGTH, 32'(sbi_pkg::LENGTH_RST));
		rd(8'h14, 32'h0);
		chk(32'(er), 32'h1);
	endtask

	task automatic t_flags;
		for (int i = 0; i < 14; i++)
		begin
			ev(t_e[i], t_c[i]);
			chk(32'(vec), 32'(|t_s[i]));
			rd(sbi_pkg::ADDR_STATUS, 32'(t_s[i]));
			apb(1'b1, sbi_pkg::ADDR_STATUS, 32'h7f);
			rd(sbi_pkg::ADDR_STATUS, 32'h0);
		end
	endtask

	task automatic t_irq;
		ev(13'h1000, 7'h61);
		chk(32'(irq), 32'h0);
		apb(1'b1, sbi_pkg::ADDR_MASK, 32'h01);
		rd(sbi_pkg::ADDR_MASK, 32'h01);
		chk(32'(irq), 32'h1);
		apb(1'b1, sbi_pkg::ADDR_STATUS, 32'h01);
		rd(sbi_pkg::ADDR_STATUS, 32'h0);
		chk(32'(irq), 32'h0);
	endtask

	task automatic t_tx;
		apb(1'b1, sbi_pkg::ADDR_LENGTH, 32'h02);
		ev(13'h0001, 7'h25);
		ev(13'h0002, 7'h25);
		chk(32'({dma, vec}), 32'h2);
		rd(sbi_pkg::ADDR_STATUS, 32'h20);
		serve();
		ev(13'h0018, 7'h25);
		rd(sbi_pkg::ADDR_SCNT, 32'h1);
		ev(13'h0002, 7'h25);
		rd(sbi_pkg::ADDR_STATUS, 32'h0);
		ev(13'h0018, 7'h25);
		rd(sbi_pkg::ADDR_STATUS, 32'h08);
		rd(sbi_pkg::ADDR_FCNT, 32'h1e);
		apb(1'b1, sbi_pkg::ADDR_STATUS, 32'h7f);
		repeat (30) ev(13'h0010, 7'h25);
		rd(sbi_pkg::ADDR_STATUS, 32'h10);
		rd(sbi_pkg::ADDR_SCNT, 32'h0);
		apb(1'b1, sbi_pkg::ADDR_STATUS, 32'h7f);
	endtask

	task automatic t_rx;
		ev(13'h0001, 7'h05);
		ev(13'h0018, 7'h05);
		rd(sbi_pkg::ADDR_STATUS, 32'h0);
		ev(13'h0014, 7'h05);
		chk(32'({dma, vec}), 32'h2);
		rd(sbi_pkg::ADDR_STATUS, 32'h40);
		serve();
		rd(sbi_pkg::ADDR_STATUS, 32'h0);
	endtask

	initial
	begin
		{arst_n, psel, penable, pwrite, en} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		ctx = '0;
		evt = '0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_flags();
		t_irq();
		t_tx();
		t_rx();
		summarize();
	end
endmodule // sbi_irq_sources_test
